// File: common/fwp_pkg.sv
// Constants, types and carriers for the flash write-protect block.
// Assumes a 125 MHz system clock and byte-addressed Avalon-MM registers.
package fwp_pkg;

  // ***************************
  // Serial opcodes
  // ***************************
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STAT_WR   = 8'h01;
  localparam logic [7:0] OP_PROG      = 8'h02;
  localparam logic [7:0] OP_SECT      = 8'h20;
  localparam logic [7:0] OP_BLK32     = 8'h52;
  localparam logic [7:0] OP_BLK64     = 8'hd8;
  localparam logic [7:0] OP_CHIP0     = 8'h60;
  localparam logic [7:0] OP_CHIP1     = 8'hc7;
  localparam logic [7:0] OP_DPD       = 8'hb9;
  localparam logic [7:0] OP_REL       = 8'hab;

  // ***************************
  // Frame lengths in bits
  // ***************************
  localparam logic [11:0] LEN_OP   = 12'h008;
  localparam logic [11:0] LEN_ST1  = 12'h010;
  localparam logic [11:0] LEN_ST2  = 12'h018;
  localparam logic [11:0] LEN_ADDR = 12'h020;
  localparam logic [11:0] LEN_PROG = 12'h028;
  localparam logic [11:0] LEN_MAX  = 12'hfff;

  // ***************************
  // Register map and reset values
  // ***************************
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STATUS = 4'h4;
  localparam logic [3:0]  OFS_RESULT = 4'h8;
  localparam logic [3:0]  OFS_ADDR   = 4'hc;
  localparam logic        CTRL_RST   = 1'b1;
  localparam logic [7:0]  STAT_RST   = 8'h00;

  // ***************************
  // Status byte fields
  // ***************************
  localparam int ST_WEL   = 1;
  localparam int ST_BP    = 2;
  localparam int ST_LOCK0 = 7;
  localparam int ST_LOCK1 = 0;
  localparam int ST_CMP   = 6;

  // ***************************
  // Protection geometry
  // ***************************
  localparam logic [23:0] ADDR_4M  = 24'h07ffff;
  localparam logic [23:0] ADDR_2M  = 24'h03ffff;
  localparam logic [23:0] ADDR_ALL = 24'hffffff;
  localparam logic [4:0]  SZ_4K    = 5'h0c;
  localparam logic [4:0]  SZ_8K    = 5'h0d;
  localparam logic [4:0]  SZ_16K   = 5'h0e;
  localparam logic [4:0]  SZ_32K   = 5'h0f;
  localparam logic [4:0]  SZ_64K   = 5'h10;
  localparam logic [4:0]  SZ_128K  = 5'h11;
  localparam logic [4:0]  SZ_256K  = 5'h12;
  localparam logic [23:0] M_PAGE   = 24'h0000ff;
  localparam logic [23:0] M_SECT   = 24'h000fff;
  localparam logic [23:0] M_BLK32  = 24'h007fff;
  localparam logic [23:0] M_BLK64  = 24'h00ffff;

  // ***************************
  // Timing
  // ***************************
  localparam int PWR_WAIT_US  = 70;
  localparam int CLK_MHZ      = 125;
  localparam int PWR_WAIT_CYC = PWR_WAIT_US * CLK_MHZ;

  // ***************************
  // Types
  // ***************************
  typedef enum logic [2:0] {
    RES_NONE    = 3'h0,
    RES_OK      = 3'h1,
    RES_FRAME   = 3'h2,
    RES_NOLATCH = 3'h3,
    RES_PROT    = 3'h4,
    RES_DPD     = 3'h5
  } fwp_res_t;

  typedef enum logic [2:0] {
    K_PROG  = 3'h0,
    K_SECT  = 3'h1,
    K_BLK32 = 3'h2,
    K_BLK64 = 3'h3,
    K_CHIP  = 3'h4,
    K_STAT  = 3'h5
  } fwp_kind_t;

  typedef struct packed {
    logic        valid;
    fwp_kind_t   kind;
    logic [23:0] addr;
  } fwp_launch_t;

endpackage

// File: dv/fwp_chk.sv
// Port checker for the flash write-protect block.
// Assumes one clk domain; bound onto fwp_top.
`timescale 1ns/1ns
module fwp_chk #(
  parameter int PWR_WAIT = 20
) (
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic                 avs_waitrequest,
  input wire logic                 cs_n,
  input wire fwp_pkg::fwp_launch_t launch,
  input wire logic                 reject
);
  import fwp_pkg::*;
  // ****
  // Checks
  // ****
  logic [15:0] up;
  logic [15:0] next_up;
  always_comb next_up = (up == 16'hffff) ? up : up + 16'h1;
  always_ff @(posedge clk) up <= nrst ? next_up : 16'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  pulse_excl_a: assert property (!(launch.valid && reject))
    else $error("launch and reject together");
  launch_once_a: assert property (launch.valid |=> !launch.valid)
    else $error("launch longer than one cycle");
  reject_once_a: assert property (reject |=> !reject)
    else $error("reject longer than one cycle");
  launch_late_a: assert property (launch.valid |-> $past(cs_n, 1) && $past(cs_n, 2) && $past(cs_n, 3))
    else $error("launch before frame end");
  reject_late_a: assert property (reject |-> $past(cs_n, 3))
    else $error("reject before frame end");
  warm_quiet_a: assert property (up < PWR_WAIT |-> !launch.valid && !reject)
    else $error("activity during power-up wait");
  wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not in second cycle");
  wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  cover property (launch.valid);
  cover property (reject);
  cover property (avs_read && !avs_waitrequest);
endmodule // fwp_chk

bind fwp_top fwp_chk #(.PWR_WAIT(PWR_WAIT)) u_chk (.clk(clk), .nrst(nrst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .cs_n(cs_n), .launch(launch), .reject(reject));

// File: dv/fwp_host.sv
// Host model driving the serial link of the flash block.
// Assumes the bench clock; each sclk level lasts two clk cycles, each si bit four.
`timescale 1ns/1ns
module fwp_host #(
  parameter int PWR_WAIT = 20
) (
  input wire logic clk,
  input wire logic nrst,
  output logic     cs_n,
  output logic     sclk,
  output logic     si
);
  // ****
  // Frames
  // ****
  int up = 0;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  always @(posedge clk) up <= nrst ? up + 1 : 0;
  task automatic bit_out(input logic v);
    si <= v;
    repeat (2) @(posedge clk);
    sclk <= 1'b1;
    repeat (2) @(posedge clk);
    sclk <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] q[$], input int extra);
    while (up < PWR_WAIT + 4) @(posedge clk);
    cs_n <= 1'b0;
    foreach (q[i])
      for (int k = 7; k >= 0; k--) bit_out(q[i][k]);
    for (int k = 0; k < extra; k++) bit_out(1'b1);
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    si <= ~si;
    repeat (10) @(posedge clk);
  endtask
endmodule // fwp_host

// File: dv/test_flash_write_protect_decode.sv
// Self-checking bench for the flash write-protect block.
// Assumes the host model on the serial pins and Avalon-MM registers.
`timescale 1ns/1ns
module test_flash_write_protect_decode;
  import fwp_pkg::*;
  // ****
  // Bench
  // ****
  logic        clk;
  logic        nrst;
  logic        avs_read;
  logic        avs_write;
  logic        avs_waitrequest;
  logic        wp_n;
  logic        cs_n;
  logic        sclk;
  logic        si;
  logic        reject;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] d;
  fwp_launch_t launch;
  fwp_launch_t last;
  int          err_total = 0;
  int          n_tests = 0;
  int          n_launch = 0;
  int          n_rej = 0;
  logic [31:0] tbl [18] = '{
    32'h83070000, 32'h8206f000, 32'h9300f000, 32'h92010000, 32'h89000000,
    32'hc107f000, 32'hc8000000, 32'hc2070000, 32'hc306f000,
    32'ha307f000, 32'ha207e000, 32'hb5001000, 32'hb4002000, 32'haf000000,
    32'h0b030000, 32'h0a02f000, 32'h07000000, 32'h0803f000};
  fwp_top #(.PWR_WAIT(20)) u_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cs_n(cs_n), .sclk(sclk), .si(si), .wp_n(wp_n), .launch(launch),
    .reject(reject));
  fwp_host #(.PWR_WAIT(20)) u_host (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .si(si));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (launch.valid === 1'b1)
    begin
      n_launch++;
      last = launch;
    end
    if (reject === 1'b1) n_rej++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    d = avs_readdata;
    if (avs_waitrequest !== 1'b0)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk_res(input fwp_res_t r);
    bus(1'b0, OFS_RESULT, 32'h0);
    chk({29'h0, d[18:16]}, {29'h0, r});
  endtask
  task automatic t_reset;
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(d & 32'hfffdffff, 32'h00040000);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(d, {31'h0, CTRL_RST});
    bus(1'b1, 4'h1, 32'hffffffff);
    bus(1'b0, 4'h1, 32'h0);
    chk(d, 32'h0);
  endtask
  task automatic t_latch;
    u_host.frame('{OP_PROG, 8'h00, 8'h10, 8'h00, 8'ha5}, 0);
    chk(n_rej, 1);
    chk_res(RES_NOLATCH);
    u_host.frame('{OP_SET_LATCH}, 0);
    u_host.frame('{OP_PROG, 8'h00, 8'h10, 8'h00, 8'ha5}, 0);
    chk(last, {4'h0, 1'b1, K_PROG, 24'h001000});
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(d[ST_WEL], 1'b0);
  endtask
  task automatic t_frame;
    u_host.frame('{OP_SET_LATCH}, 0);
    u_host.frame('{OP_SECT, 8'h00, 8'h20, 8'h00}, 3);
    chk_res(RES_FRAME);
    u_host.frame('{OP_SECT, 8'h00, 8'h20}, 0);
    chk_res(RES_FRAME);
    chk(n_launch, 1);
  endtask
  task automatic t_wp;
    wp_n <= 1'b0;
    u_host.frame('{OP_SET_LATCH}, 0);
    u_host.frame('{OP_STAT_WR, 8'h8c}, 0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(d[7:2], 6'h00);
    wp_n <= 1'b1;
    u_host.frame('{OP_SET_LATCH}, 0);
    u_host.frame('{OP_STAT_WR, 8'h8c}, 0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(d[7:2], 6'h23);
  endtask
  task automatic t_decode;
    logic [31:0] e;
    int nl;
    int nr;
    foreach (tbl[i])
    begin
      e = tbl[i];
      bus(1'b1, OFS_CTRL, {31'h0, e[31]});
      u_host.frame('{OP_SET_LATCH}, 0);
      u_host.frame('{OP_STAT_WR, {1'b0, e[29:25], 2'b00}, {1'b0, e[30], 6'h00}}, 0);
      u_host.frame('{OP_SET_LATCH}, 0);
      nl = n_launch;
      nr = n_rej;
      u_host.frame('{OP_SECT, e[23:16], e[15:8], e[7:0]}, 0);
      chk((n_launch - nl) * 2 + (n_rej - nr), e[24] ? 1 : 2);
    end
  endtask
  task automatic t_dpd;
    u_host.frame('{OP_DPD}, 0);
    u_host.frame('{OP_SET_LATCH}, 0);
    chk_res(RES_DPD);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({d[16], d[ST_WEL]}, 2'b10);
    u_host.frame('{OP_REL}, 0);
    u_host.frame('{OP_SET_LATCH}, 0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({d[16], d[ST_WEL]}, 2'b01);
  endtask
  task automatic t_rerst;
    u_host.frame('{OP_SET_LATCH}, 0);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(d, 32'h00040000);
    u_host.frame('{OP_SET_LATCH}, 0);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk(d[ST_WEL], 1'b1);
  endtask
  task automatic test_done;
    $display("TB: errors=%0d checks=%0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    err_total++;
    test_done;
  end
  initial
  begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    wp_n = 1'b1;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_latch;
    t_frame;
    t_wp;
    t_decode;
    t_dpd;
    t_rerst;
    test_done;
  end
endmodule // test_flash_write_protect_decode

// File: hw/fwp_top.sv
// Write-protect and command gating for a small serial flash.
// Assumes serial pins slower than clk/4; array and write timing live outside.
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns

module fwp_top #(
  parameter int PWR_WAIT = fwp_pkg::PWR_WAIT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 cs_n,
  input  wire logic                 sclk,
  input  wire logic                 si,
  input  wire logic                 wp_n,
  output fwp_pkg::fwp_launch_t      launch,
  output logic                      reject
);
  import fwp_pkg::*;

  typedef enum logic [1:0] {
    ST_PWRUP = 2'b00,
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } fwp_state_t;

  // ***************************
  // Pin synchronisers
  // ***************************
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic       sclk_d;
  logic       cs_hi;
  logic       sclk_rise;
  logic       si_s;
  logic       wp_s;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pin_s1 <= 4'h9;
      pin_s2 <= 4'h9;
      sclk_d <= 1'b0;
    end
    else
    begin
      pin_s1 <= {cs_n, sclk, si, wp_n};
      pin_s2 <= pin_s1;
      sclk_d <= pin_s2[2];
    end
  end

  assign cs_hi     = pin_s2[3];
  assign sclk_rise = pin_s2[2] & ~sclk_d;
  assign si_s      = pin_s2[1];
  assign wp_s      = pin_s2[0];

  // ***************************
  // Protection decode
  // ***************************
  function automatic logic prot_at(
    input logic [23:0] a,
    input logic [4:0]  bp,
    input logic        cmp,
    input logic        big
  );
    logic        none;
    logic        all;
    logic [4:0]  sz;
    logic [23:0] am;
    logic [23:0] ax;
    logic        hit;
    none = 1'b0;
    all  = 1'b0;
    sz   = SZ_4K;
    if (!bp[4] && big)
    begin
      if (bp[2])
        all = 1'b1;
      else
        unique case (bp[1:0])
          2'h0: none = 1'b1;
          2'h1: sz = SZ_64K;
          2'h2: sz = SZ_128K;
          2'h3: sz = SZ_256K;
        endcase
    end
    else if (!bp[4])
    begin
      unique case (bp[1:0])
        2'h0: none = 1'b1;
        2'h1: sz = SZ_64K;
        2'h2: sz = SZ_128K;
        2'h3: all = 1'b1;
      endcase
    end
    else
    begin
      unique case (bp[2:0])
        3'h0: none = 1'b1;
        3'h1: sz = SZ_4K;
        3'h2: sz = SZ_8K;
        3'h3: sz = SZ_16K;
        3'h4, 3'h5, 3'h6: sz = SZ_32K;
        3'h7: all = 1'b1;
      endcase
    end
    am  = big ? ADDR_4M : ADDR_2M;
    ax  = a & am;
    hit = all | (!none & (bp[3] ? ((ax >> sz) == 24'h0)
                               : (((ax | ~am) >> sz) == (ADDR_ALL >> sz))));
    return hit ^ cmp;
  endfunction

  // ***************************
  // Command state
  // ***************************
  fwp_state_t  state, next_state;
  logic [13:0] pwr_cnt, next_pwr_cnt;
  logic [11:0] cnt, next_cnt;
  logic [31:0] sh, next_sh;
  logic [4:0]  bp, next_bp;
  logic [1:0]  lock, next_lock;
  logic        cmp, next_cmp;
  logic        write_latch_bit, next_wel;
  logic        dpd, next_dpd;
  fwp_res_t    res, next_res;
  logic [7:0]  lop, next_lop;
  logic [23:0] laddr, next_laddr;
  fwp_launch_t next_launch;
  logic        next_reject;
  logic        big;

  logic [31:0] sh_al;
  logic [7:0]  op;
  logic [23:0] fa;
  logic [7:0]  sd1;
  logic        aligned;
  logic        is_mod;
  fwp_kind_t   kind;
  logic [23:0] m;
  logic        len_ok;
  logic        prot;

  assign sh_al   = sh >> 5'(cnt[4:0] - 5'h8);
  assign op      = (cnt >= LEN_ADDR) ? sh[31:24] : sh_al[7:0];
  assign fa      = sh[23:0];
  assign sd1     = (cnt == LEN_ST1) ? sh[7:0] : sh[15:8];
  assign aligned = (cnt[2:0] == 3'h0) && (cnt != 12'h0);

  always_comb
  begin
    is_mod = 1'b1;
    kind   = K_PROG;
    m      = M_PAGE;
    len_ok = (cnt == LEN_ADDR);
    unique case (op)
      OP_PROG:
      begin
        len_ok = (cnt >= LEN_PROG);
      end
      OP_SECT:  begin kind = K_SECT;  m = M_SECT;  end
      OP_BLK32: begin kind = K_BLK32; m = M_BLK32; end
      OP_BLK64: begin kind = K_BLK64; m = M_BLK64; end
      OP_CHIP0, OP_CHIP1:
      begin
        kind   = K_CHIP;
        m      = ADDR_ALL;
        len_ok = (cnt == LEN_OP);
      end
      default:
      begin
        is_mod = 1'b0;
        len_ok = (cnt == LEN_OP);
      end
    endcase
  end

  assign prot = prot_at(fa & ~m, bp, cmp, big) | prot_at(fa | m, bp, cmp, big);

  always_comb
  begin
    next_state   = state;
    next_pwr_cnt = pwr_cnt;
    next_cnt     = cnt;
    next_sh      = sh;
    next_bp      = bp;
    next_lock    = lock;
    next_cmp     = cmp;
    next_wel     = write_latch_bit;
    next_dpd     = dpd;
    next_res     = res;
    next_lop     = lop;
    next_laddr   = laddr;
    next_launch  = '0;
    next_reject  = 1'b0;
    unique case (state)
      ST_PWRUP:
      begin
        if (pwr_cnt != 14'(PWR_WAIT))
          next_pwr_cnt = pwr_cnt + 14'h1;
        else if (cs_hi)
          next_state = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (!cs_hi)
        begin
          next_state = ST_SHIFT;
          next_cnt   = 12'h0;
          next_sh    = 32'h0;
        end
      end
      ST_SHIFT:
      begin
        if (!cs_hi)
        begin
          if (sclk_rise)
          begin
            if (cnt < LEN_ADDR)
              next_sh = {sh[30:0], si_s};
            if (cnt != LEN_MAX)
              next_cnt = cnt + 12'h1;
          end
        end
        else
        begin
          next_state = ST_IDLE;
          next_lop   = op;
          next_laddr = fa;
          if (dpd)
          begin
            if (op == OP_REL && cnt == LEN_OP)
            begin
              next_dpd = 1'b0;
              next_res = RES_OK;
            end
            else
            begin
              next_res    = RES_DPD;
              next_reject = 1'b1;
            end
          end
          else if (!aligned)
          begin
            next_res    = RES_FRAME;
            next_reject = 1'b1;
          end
          else if (op == OP_STAT_WR)
          begin
            if (cnt != LEN_ST1 && cnt != LEN_ST2)
            begin
              next_res    = RES_FRAME;
              next_reject = 1'b1;
            end
            else if (!write_latch_bit)
            begin
              next_res    = RES_NOLATCH;
              next_reject = 1'b1;
            end
            else
            begin
              if (wp_s)
              begin
                next_bp   = sd1[ST_BP +: 5];
                next_lock[0] = sd1[ST_LOCK0];
                if (cnt == LEN_ST2)
                  next_lock[1] = sh[ST_LOCK1];
              end
              if (cnt == LEN_ST2)
                next_cmp = sh[ST_CMP];
              next_wel         = 1'b0;
              next_res         = RES_OK;
              next_launch.valid = 1'b1;
              next_launch.kind  = K_STAT;
            end
          end
          else if (is_mod)
          begin
            if (!len_ok)
            begin
              next_res    = RES_FRAME;
              next_reject = 1'b1;
            end
            else if (!write_latch_bit)
            begin
              next_res    = RES_NOLATCH;
              next_reject = 1'b1;
            end
            else if (prot)
            begin
              next_res    = RES_PROT;
              next_reject = 1'b1;
            end
            else
            begin
              next_wel          = 1'b0;
              next_res          = RES_OK;
              next_launch.valid = 1'b1;
              next_launch.kind  = kind;
              next_launch.addr  = fa;
            end
          end
          else if (len_ok && op == OP_SET_LATCH)
          begin
            next_wel = 1'b1;
            next_res = RES_OK;
          end
          else if (len_ok && op == OP_CLR_LATCH)
          begin
            next_wel = 1'b0;
            next_res = RES_OK;
          end
          else if (len_ok && op == OP_DPD)
          begin
            next_dpd = 1'b1;
            next_res = RES_OK;
          end
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state   <= ST_PWRUP;
      pwr_cnt <= 14'h0;
      cnt     <= 12'h0;
      sh      <= 32'h0;
      bp      <= STAT_RST[ST_BP +: 5];
      lock    <= 2'h0;
      cmp     <= 1'b0;
      write_latch_bit     <= 1'b0;
      dpd     <= 1'b0;
      res     <= RES_NONE;
      lop     <= 8'h0;
      laddr   <= 24'h0;
      launch  <= '0;
      reject  <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      pwr_cnt <= next_pwr_cnt;
      cnt     <= next_cnt;
      sh      <= next_sh;
      bp      <= next_bp;
      lock    <= next_lock;
      cmp     <= next_cmp;
      write_latch_bit     <= next_wel;
      dpd     <= next_dpd;
      res     <= next_res;
      lop     <= next_lop;
      laddr   <= next_laddr;
      launch  <= next_launch;
      reject  <= next_reject;
    end
  end

  // ***************************
  // Avalon-MM slave
  // ***************************
  logic        ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic        next_big;
  logic        req;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign avs_readdata    = rdata;

  always_comb
  begin
    next_ack   = req & ~ack;
    next_rdata = rdata;
    next_big   = big;
    if (avs_write && ack && avs_address == OFS_CTRL)
      next_big = avs_writedata[0];
    if (avs_read && !ack)
    begin
      unique case (avs_address)
        OFS_CTRL:   next_rdata = {31'h0, big};
        OFS_STATUS: next_rdata = {13'h0, wp_s, (state != ST_PWRUP), dpd, 1'b0, cmp, 5'h0,
                                  lock[1], lock[0], bp, write_latch_bit, 1'b0};
        OFS_RESULT: next_rdata = {13'h0, res, 8'h0, lop};
        OFS_ADDR:   next_rdata = {8'h0, laddr};
        default:    next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ack   <= 1'b0;
      rdata <= 32'h0;
      big   <= CTRL_RST;
    end
    else
    begin
      ack   <= next_ack;
      rdata <= next_rdata;
      big   <= next_big;
    end
  end

endmodule // fwp_top
